// >>> design/regfile_consts.vh
// Purpose: constants for the core register file and context block
// Assumes: 100 MHz clk_i, synchronous inputs
// Notes: special register indices, fields and the common reset word live here
// Functional notes
// - sixteen data and sixteen address registers, each 32 bits wide.
// - data register 15 is the implicit data operand.
// - address register 10 is the running task's stack pointer.
// - address register 11 holds the return address.
// - address register 15 is the implicit address operand.
// - indices 0..7 form the lower group, 8..15 the upper group.
// - address registers 0, 1, 8, 9 are global and never saved or restored.
// - addresses are 32 bits, one 4 GByte unified space.
// - sixteen 256 MByte segments picked by the top four address bits.
// - a save area is sixteen words, aligned to sixteen words.
// - one area holds one upper or lower context, chained by link word.
// - saved state is registers, pointer, link word and status, in halves.
// - interrupts, traps and calls each start a hardware context switch.
// - lowest user mode cannot toggle interrupts and has no peripheral access.
// - second user mode reaches unprotected peripherals and may disable interrupts.
// - supervisor reaches system registers and all peripherals, may disable interrupts.
// - privilege mode comes from the status word's I/O mode field.
// - bytes are little-endian in memory and registers.
// - packed operations see a register as two 16-bit or four 8-bit lanes.
// - accepted service requests jump to a per-source code block vector.
`ifndef REGFILE_CONSTS_VH
`define REGFILE_CONSTS_VH
`define IDX_IMPL_DATA     4'h0f
`define IDX_STACK_PTR     4'h0a
`define IDX_RET_ADDR      4'h0b
`define IDX_IMPL_ADDR     4'h0f
`define IDX_UPPER_BIT     3
`define CSA_WORDS         5'h10
`define CSA_ALIGN_BITS    6
`define SEG_HI            31
`define SEG_LO            28
`define IOMODE_HI         11
`define IOMODE_LO         10
`define IOMODE_USER0      2'h0
`define IOMODE_USER1      2'h1
`define IOMODE_SUPER      2'h2
`define VEC_SHIFT         5
`define RST_WORD          32'h0000_0000
`define CTX_LOWER         1'b0
`define CTX_UPPER         1'b1
`endif

// >>> design/gpr_bank.v
// Purpose: one 16 x 32 register bank with bypassed read
// Assumes: single write port, two read ports
// Notes: write data forwarded to both read ports so a same-cycle read never sees a stale word
`include "regfile_consts.vh"
`default_nettype none
module gpr_bank (
  input  wire        clk_i,   // clock
  input  wire        rst_i,   // async reset
  input  wire        ce_i,    // clock enable
  input  wire        we_i,    // write strobe
  input  wire [3:0]  widx_i,  // write index
  input  wire [31:0] wdata_i, // write data
  input  wire [3:0]  ridx_a_i,// read index a
  input  wire [3:0]  ridx_b_i,// read index b
  output wire [31:0] rdata_a_o,// read data a
  output wire [31:0] rdata_b_o,// read data b
  output wire [511:0] flat_o  // all registers, for context save
);
  reg [31:0] mem_q [0:15];
  genvar g;
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_reg
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          mem_q[g] <= `RST_WORD;
        end else if (ce_i && we_i && widx_i == g) begin
          mem_q[g] <= wdata_i;
        end
      end
      assign flat_o[g*32 +: 32] = mem_q[g];
    end
  endgenerate
  // same-cycle write wins over stored copy
  // no forward while frozen: the write will not land
  assign rdata_a_o = (ce_i && we_i && widx_i == ridx_a_i) ? wdata_i : mem_q[ridx_a_i];
  assign rdata_b_o = (ce_i && we_i && widx_i == ridx_b_i) ? wdata_i : mem_q[ridx_b_i];
endmodule // gpr_bank
`default_nettype wire

// >>> design/core_register_file_context.v
// Purpose: architectural registers, context save sequencing, decode helpers
// Assumes: pipeline asks for switches; context memory takes one word per beat
// Notes: registers are little-endian words; byte 0 is bits 7:0
`include "regfile_consts.vh"
`default_nettype none
module core_register_file_context (
  input  wire        clk_i,            // clock, 100 MHz
  input  wire        rst_i,            // async reset, active high
  input  wire        ce_i,             // clock enable
  input  wire        d_we_i,           // data register write
  input  wire [3:0]  d_widx_i,         // data write index
  input  wire [31:0] d_wdata_i,        // data write value
  input  wire [3:0]  d_ridx_i,         // data read index
  input  wire        d_implicit_i,     // use implicit data register
  output wire [31:0] d_rdata_o,        // data read value
  input  wire        a_we_i,           // address register write
  input  wire [3:0]  a_widx_i,         // address write index
  input  wire [31:0] a_wdata_i,        // address write value
  input  wire [3:0]  a_ridx_i,         // address read index
  input  wire        a_implicit_i,     // use implicit address register
  output wire [31:0] a_rdata_o,        // address read value
  output wire [31:0] stack_pointer_o,  // stack pointer register
  output wire [31:0] return_address_o, // return address register
  output wire        d_upper_o,        // read data index is upper group
  input  wire [1:0]  lane_mode_i,      // 0 word, 1 two half lanes, 2 four byte lanes
  output wire [3:0]  lane_valid_o,     // lanes in use for packed op
  output wire [7:0]  byte0_o,          // least significant byte of data read
  input  wire        psw_we_i,         // status word write
  input  wire [31:0] psw_wdata_i,      // status word value
  input  wire        previous_context_info_we_i,        // context info write
  input  wire [31:0] previous_context_info_wdata_i,     // context info value
  input  wire        ip_we_i,          // instruction pointer write
  input  wire [31:0] ip_wdata_i,       // instruction pointer value
  output reg  [31:0] program_status_word_o,   // status word
  output reg  [31:0] previous_context_info_o, // context info
  output reg  [31:0] instruction_pointer_o,   // instruction pointer
  output wire        priv_user0_o,     // lowest user mode
  output wire        priv_user1_o,     // second user mode
  output wire        priv_super_o,     // supervisor mode
  input  wire        irq_toggle_req_i, // task tries to toggle interrupts
  input  wire        irq_disable_req_i,// task tries to disable interrupts
  input  wire        periph_req_i,     // peripheral access attempt
  input  wire        periph_protected_i, // target peripheral is protected
  input  wire        sysreg_req_i,     // system register access attempt
  output wire        irq_ctl_ok_o,     // interrupt control permitted
  output wire        periph_ok_o,      // peripheral access permitted
  output wire        sysreg_ok_o,      // system register access permitted
  input  wire [31:0] addr_i,           // address to decode
  output wire [3:0]  segment_o,        // segment of addr_i
  input  wire        brk_irq_i,        // accepted service request
  input  wire        brk_trap_i,       // trap taken
  input  wire        brk_call_i,       // function call
  input  wire [7:0]  irq_src_i,        // accepted source number
  input  wire [31:0] vec_base_i,       // handler vector base
  output reg  [31:0] vector_addr_o,    // jump target for service request
  input  wire        ctx_upper_i,      // which half to save
  input  wire [31:0] csa_addr_i,       // free save area address
  input  wire [31:0] link_word_i,      // link to previous area
  output reg         csa_we_o,         // save area word write
  output reg  [31:0] csa_waddr_o,      // save area word address
  output reg  [31:0] csa_wdata_o,      // save area word data
  input  wire        csa_ready_i,      // context memory takes word
  output wire        ctx_busy_o,       // context save in progress
  output reg         ctx_done_o,       // one-cycle save complete
  output reg         csa_align_err_o   // save area not aligned
);
  localparam S_IDLE = 1'b0;
  localparam S_SAVE = 1'b1;
  reg         state_q;
  reg         half_q;
  reg [3:0]   beat_q;
  reg [31:0]  base_q;
  reg [31:0]  link_q;
  wire [511:0] d_flat;
  wire [511:0] a_flat;
  wire [3:0]  d_ridx;
  wire [3:0]  a_ridx;
  wire [1:0]  iomode;
  wire        brk_any;
  reg  [31:0] save_word;
  // ------------------------------------------------------------
  // register banks
  // ------------------------------------------------------------
  assign d_ridx = d_implicit_i ? `IDX_IMPL_DATA : d_ridx_i;
  assign a_ridx = a_implicit_i ? `IDX_IMPL_ADDR : a_ridx_i;
  gpr_bank u_data (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .we_i      (d_we_i),
    .widx_i    (d_widx_i),
    .wdata_i   (d_wdata_i),
    .ridx_a_i  (d_ridx),
    .ridx_b_i  (`IDX_IMPL_DATA),
    .rdata_a_o (d_rdata_o),
    .rdata_b_o (),
    .flat_o    (d_flat)
  );
  gpr_bank u_addr (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .we_i      (a_we_i),
    .widx_i    (a_widx_i),
    .wdata_i   (a_wdata_i),
    .ridx_a_i  (a_ridx),
    .ridx_b_i  (`IDX_STACK_PTR),
    .rdata_a_o (a_rdata_o),
    .rdata_b_o (stack_pointer_o),
    .flat_o    (a_flat)
  );
  assign return_address_o = a_flat[`IDX_RET_ADDR*32 +: 32];
  assign d_upper_o = d_ridx[`IDX_UPPER_BIT];
  // ------------------------------------------------------------
  // packed lanes and byte order
  // ------------------------------------------------------------
  assign lane_valid_o = (lane_mode_i == 2'h1) ? 4'h3 :
                        (lane_mode_i == 2'h2) ? 4'hf : 4'h1;
  assign byte0_o = d_rdata_o[7:0];
  // ------------------------------------------------------------
  // system registers and privilege
  // ------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      program_status_word_o   <= `RST_WORD;
      previous_context_info_o <= `RST_WORD;
      instruction_pointer_o   <= `RST_WORD;
    end else if (ce_i) begin
      if (psw_we_i) begin
        program_status_word_o <= psw_wdata_i;
      end
      if (previous_context_info_we_i) begin
        previous_context_info_o <= previous_context_info_wdata_i;
      end
      if (ip_we_i) begin
        instruction_pointer_o <= ip_wdata_i;
      end
    end
  end
  assign iomode = program_status_word_o[`IOMODE_HI:`IOMODE_LO];
  assign priv_user0_o = (iomode == `IOMODE_USER0);
  assign priv_user1_o = (iomode == `IOMODE_USER1);
  // reserved code 3 treated as supervisor
  assign priv_super_o = !priv_user0_o && !priv_user1_o;
  // user0 may neither enable nor disable; user1 only disable
  assign irq_ctl_ok_o = priv_super_o ||
                        (priv_user1_o && irq_disable_req_i && !irq_toggle_req_i);
  assign periph_ok_o  = periph_req_i && (priv_super_o ||
                        (priv_user1_o && !periph_protected_i));
  assign sysreg_ok_o  = sysreg_req_i && priv_super_o;
  // ------------------------------------------------------------
  // address decode and vectoring
  // ------------------------------------------------------------
  assign segment_o = addr_i[`SEG_HI:`SEG_LO];
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vector_addr_o <= `RST_WORD;
    end else if (ce_i && brk_irq_i) begin
      vector_addr_o <= vec_base_i | ({24'h00_0000, irq_src_i} << `VEC_SHIFT);
    end
  end
  // ------------------------------------------------------------
  // context save sequencer
  // ------------------------------------------------------------
  assign brk_any = brk_irq_i || brk_trap_i || brk_call_i;
  assign ctx_busy_o = (state_q == S_SAVE);
  // word 0 link, words 1..15 by half; global address regs are never saved
  always @* begin
    save_word = `RST_WORD;
    if (beat_q == 4'h0) begin
      save_word = link_q;
    end else if (half_q == `CTX_UPPER) begin
      case (beat_q)
        4'h1: save_word = program_status_word_o;
        4'h2: save_word = a_flat[`IDX_STACK_PTR*32 +: 32];
        4'h3: save_word = a_flat[`IDX_RET_ADDR*32 +: 32];
        4'h4: save_word = d_flat[8*32 +: 32];
        4'h5: save_word = d_flat[9*32 +: 32];
        4'h6: save_word = d_flat[10*32 +: 32];
        4'h7: save_word = d_flat[11*32 +: 32];
        4'h8: save_word = a_flat[12*32 +: 32];
        4'h9: save_word = a_flat[13*32 +: 32];
        4'ha: save_word = a_flat[14*32 +: 32];
        4'hb: save_word = a_flat[15*32 +: 32];
        4'hc: save_word = d_flat[12*32 +: 32];
        4'hd: save_word = d_flat[13*32 +: 32];
        4'he: save_word = d_flat[14*32 +: 32];
        4'hf: save_word = d_flat[15*32 +: 32];
        default: save_word = `RST_WORD;
      endcase
    end else begin
      case (beat_q)
        4'h1: save_word = a_flat[11*32 +: 32];
        4'h2: save_word = a_flat[2*32 +: 32];
        4'h3: save_word = a_flat[3*32 +: 32];
        4'h4: save_word = d_flat[0*32 +: 32];
        4'h5: save_word = d_flat[1*32 +: 32];
        4'h6: save_word = d_flat[2*32 +: 32];
        4'h7: save_word = d_flat[3*32 +: 32];
        4'h8: save_word = a_flat[4*32 +: 32];
        4'h9: save_word = a_flat[5*32 +: 32];
        4'ha: save_word = a_flat[6*32 +: 32];
        4'hb: save_word = a_flat[7*32 +: 32];
        4'hc: save_word = d_flat[4*32 +: 32];
        4'hd: save_word = d_flat[5*32 +: 32];
        4'he: save_word = d_flat[6*32 +: 32];
        4'hf: save_word = d_flat[7*32 +: 32];
        default: save_word = `RST_WORD;
      endcase
    end
  end
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q         <= S_IDLE;
      half_q          <= `CTX_LOWER;
      beat_q          <= 4'h0;
      base_q          <= `RST_WORD;
      link_q          <= `RST_WORD;
      csa_we_o        <= 1'b0;
      csa_waddr_o     <= `RST_WORD;
      csa_wdata_o     <= `RST_WORD;
      ctx_done_o      <= 1'b0;
      csa_align_err_o <= 1'b0;
    end else if (ce_i) begin
      ctx_done_o <= 1'b0;
      case (state_q)
        S_IDLE: begin
          csa_we_o <= 1'b0;
          if (brk_any) begin
            // a misaligned area would overlap its neighbour
            if (csa_addr_i[`CSA_ALIGN_BITS-1:0] != 6'h00) begin
              csa_align_err_o <= 1'b1;
            end else begin
              csa_align_err_o <= 1'b0;
              state_q <= S_SAVE;
              half_q  <= ctx_upper_i;
              beat_q  <= 4'h0;
              base_q  <= csa_addr_i;
              link_q  <= link_word_i;
            end
          end
        end
        S_SAVE: begin
          // hold word until memory takes it
          if (!csa_we_o || csa_ready_i) begin
            // beat count wrapped: all sixteen words have been taken
            if (csa_we_o && beat_q == 4'h0) begin
              csa_we_o   <= 1'b0;
              state_q    <= S_IDLE;
              ctx_done_o <= 1'b1;
            end else begin
              csa_we_o    <= 1'b1;
              csa_wdata_o <= save_word;
              csa_waddr_o <= base_q + {26'h000_0000, beat_q, 2'h0};
              beat_q      <= beat_q + 4'h1;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // core_register_file_context
`default_nettype wire

// >>> tb/core_register_file_context_properties.sv
// Purpose: port-level checks for the register file and context block
// Assumes: one clock, async active-high reset
// Notes: bound to every instance of the top module
`default_nettype none
module core_register_file_context_properties (
  input wire logic        clk_i, rst_i, ce_i,            // clock, reset, enable
  input wire logic [3:0]  a_ridx_i, segment_o,           // read index, segment
  input wire logic        a_implicit_i,                  // implicit address read
  input wire logic [31:0] a_rdata_o, stack_pointer_o,    // address reads
  input wire logic [1:0]  lane_mode_i,                   // packed mode
  input wire logic [3:0]  lane_valid_o,                  // lanes in use
  input wire logic [31:0] program_status_word_o, addr_i, // status word, address
  input wire logic        priv_user0_o, priv_user1_o, priv_super_o, // modes
  input wire logic        irq_ctl_ok_o, periph_ok_o, sysreg_ok_o,   // permits
  input wire logic        periph_req_i, sysreg_req_i,    // access attempts
  input wire logic        brk_irq_i, brk_trap_i, brk_call_i, // breaks
  input wire logic [7:0]  irq_src_i,                     // source number
  input wire logic [31:0] vec_base_i, vector_addr_o,     // vector base, target
  input wire logic [31:0] csa_addr_i, csa_waddr_o, csa_wdata_o, // save area
  input wire logic        csa_we_o, csa_ready_i, ctx_busy_o,     // beat handshake
  input wire logic        ctx_done_o, csa_align_err_o    // completion, fault
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence brk_idle_s;
    !ctx_busy_o && ce_i && (brk_irq_i || brk_trap_i || brk_call_i);
  endsequence
  sequence first_beat_s;
    ##2 csa_we_o && csa_waddr_o == $past(csa_addr_i, 2);
  endsequence
  seg_decode_a: assert property (segment_o == addr_i[31:28]) else $error("bad segment");
  stack_alias_a: assert property (a_ridx_i == 4'h0a && !a_implicit_i |->
    a_rdata_o == stack_pointer_o) else $error("stack pointer mismatch");
  lane_map_a: assert property (lane_mode_i != 2'h3 |-> lane_valid_o ==
    {{2{lane_mode_i[1]}}, |lane_mode_i, 1'h1}) else $error("bad lanes");
  mode_decode_a: assert property (priv_user0_o == (program_status_word_o[11:10] == 2'h0)
    && priv_user1_o == (program_status_word_o[11:10] == 2'h1)
    && priv_super_o == program_status_word_o[11]) else $error("bad mode");
  user0_block_a: assert property (priv_user0_o |-> !irq_ctl_ok_o && !periph_ok_o
    && !sysreg_ok_o) else $error("user0 permit");
  super_grant_a: assert property (priv_super_o && periph_req_i && sysreg_req_i |->
    periph_ok_o && sysreg_ok_o) else $error("supervisor denied");
  save_start_a: assert property (brk_idle_s ##0 csa_addr_i[5:0] == 6'h00 |->
    first_beat_s) else $error("no link beat");
  word_hold_a: assert property (csa_we_o && !csa_ready_i |=> csa_we_o &&
    $stable(csa_waddr_o) && $stable(csa_wdata_o)) else $error("beat dropped");
  word_step_a: assert property (csa_we_o && csa_ready_i && csa_waddr_o[5:2] != 4'hf
    |=> csa_we_o && csa_waddr_o == $past(csa_waddr_o) + 32'h0000_0004)
    else $error("bad beat address");
  last_beat_a: assert property (csa_we_o && csa_ready_i && csa_waddr_o[5:2] == 4'hf
    |=> !csa_we_o && ctx_done_o ##1 !ctx_done_o) else $error("bad end");
  misalign_a: assert property (brk_idle_s ##0 csa_addr_i[5:0] != 6'h00 |=>
    csa_align_err_o && !csa_we_o ##1 !csa_we_o) else $error("misaligned save");
  vector_a: assert property (brk_irq_i && !ctx_busy_o && ce_i |=> vector_addr_o ==
    ($past(vec_base_i) | {$past(irq_src_i), 5'h00})) else $error("bad vector");
endmodule // core_register_file_context_properties
bind core_register_file_context core_register_file_context_properties props (.*);
`default_nettype wire

// >>> tb/ctx_memory_model.sv
// Purpose: context memory taking save-area beats
// Assumes: beats held until ready is seen
// Notes: slow mode accepts every other cycle
`default_nettype none
module ctx_memory_model (
  input  wire logic        clk_i, rst_i, slow_i, csa_we_i, // clock, reset, mode, beat
  input  wire logic [31:0] waddr_i, wdata_i,               // beat address, data
  output logic             ready_o                         // beat taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [31:0] mem_q [0:63];
  logic        pat_q;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) pat_q <= 1'h0;
    else pat_q <= slow_i ? ~pat_q : 1'h1;
  end
  assign ready_o = csa_we_i && pat_q;
  always @(posedge clk_i) begin
    if (csa_we_i && ready_o) mem_q[waddr_i[7:2]] <= wdata_i;
  end
endmodule // ctx_memory_model
`default_nettype wire

// >>> tb/tb.sv
// Purpose: self-checking bench for the register file and context block
// Assumes: 100 MHz clock, inputs driven 1 ns after the edge
// Notes: save words are read back from the memory model
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, ce_i, d_we_i, d_implicit_i, a_we_i, a_implicit_i, psw_we_i, slow;
  logic previous_context_info_we_i, ip_we_i, irq_toggle_req_i, irq_disable_req_i, periph_req_i, sysreg_req_i;
  logic periph_protected_i, brk_irq_i, brk_trap_i, brk_call_i, ctx_upper_i, csa_ready_i;
  logic [3:0] d_widx_i, d_ridx_i, a_widx_i, a_ridx_i, lane_valid_o, segment_o;
  logic [1:0] lane_mode_i;
  logic [7:0] irq_src_i, byte0_o;
  logic [31:0] d_wdata_i, a_wdata_i, psw_wdata_i, previous_context_info_wdata_i, ip_wdata_i, addr_i;
  logic [31:0] vec_base_i, csa_addr_i, link_word_i, d_rdata_o, a_rdata_o, stack_pointer_o;
  logic [31:0] return_address_o, program_status_word_o, previous_context_info_o;
  logic [31:0] instruction_pointer_o, vector_addr_o, csa_waddr_o, csa_wdata_o;
  logic d_upper_o, priv_user0_o, priv_user1_o, priv_super_o, irq_ctl_ok_o, periph_ok_o;
  logic sysreg_ok_o, csa_we_o, ctx_busy_o, ctx_done_o, csa_align_err_o;
  int miscompares, num_checks;
  core_register_file_context uut (.*);
  ctx_memory_model mem (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .csa_we_i(csa_we_o),
    .waddr_i(csa_waddr_o), .wdata_i(csa_wdata_o), .ready_o(csa_ready_i));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [31:0] exp_word(input logic upper, input int k);
    if (k == 0) return 32'h1234_5670;
    if (upper) begin
      if (k == 1) return 32'h0000_0c00;
      if (k < 4) return 32'h0a00_0008 + k;
      if (k < 8) return 32'h0d00_0004 + k;
      if (k < 12) return 32'h0a00_0004 + k;
      return 32'h0d00_0000 + k;
    end
    if (k == 1) return 32'h0a00_000b;
    if (k < 4) return 32'h0a00_0000 + k;
    if (k < 8) return 32'h0d00_0000 + k - 4;
    if (k < 12) return 32'h0a00_0000 + k - 4;
    return 32'h0d00_0000 + k - 8;
  endfunction
  // one break, a refused second break while busy, then the saved words
  task automatic do_save(input logic upper, input logic [2:0] kind, input logic [31:0] base);
    ctx_upper_i = upper;
    csa_addr_i = base;
    link_word_i = 32'h1234_5670;
    {brk_irq_i, brk_trap_i, brk_call_i} = kind;
    step();
    {brk_irq_i, brk_trap_i, brk_call_i} = 3'h0;
    step();
    brk_call_i = 1'h1;
    csa_addr_i = base + 32'h0000_0040;
    step();
    brk_call_i = 1'h0;
    for (int n = 0; n < 200 && ctx_done_o !== 1'h1; n++) step();
    check(ctx_done_o, 1'h1);
    check(csa_align_err_o, 1'h0);
    for (int k = 0; k < 16; k++) check(mem.mem_q[base[7:2] + k], exp_word(upper, k));
    check(mem.mem_q[base[7:2] + 16], 32'hxxxx_xxxx);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 16; i++) begin
      {d_we_i, a_we_i} = 2'h3;
      {d_widx_i, a_widx_i, d_ridx_i} = {3{4'(i)}};
      d_wdata_i = 32'h0d00_0000 + i;
      a_wdata_i = 32'h0a00_0000 + i;
      #1;
      check(d_rdata_o, d_wdata_i);
      check(d_upper_o, i > 7);
      step();
    end
    {d_we_i, a_we_i} = 2'h0;
    for (int i = 0; i < 16; i++) begin
      {d_ridx_i, a_ridx_i} = {2{4'(i)}};
      step();
      check(d_rdata_o, 32'h0d00_0000 + i);
      check(a_rdata_o, 32'h0a00_0000 + i);
    end
    {d_implicit_i, a_implicit_i, d_ridx_i, a_ridx_i} = 10'h300;
    #1;
    check(d_rdata_o, 32'h0d00_000f);
    check(byte0_o, 8'h0f);
    check(a_rdata_o, 32'h0a00_000f);
    check(stack_pointer_o, 32'h0a00_000a);
    check(return_address_o, 32'h0a00_000b);
    {d_implicit_i, a_implicit_i} = 2'h0;
    {ce_i, d_we_i, d_widx_i, d_wdata_i} = {2'h1, 4'h0, 32'hffff_ffff};
    #1;
    check(d_rdata_o, 32'h0d00_0000);
    step();
    {ce_i, d_we_i} = 2'h2;
    #1;
    check(d_rdata_o, 32'h0d00_0000);
  endtask
  task automatic t_decode;
    for (int s = 0; s < 16; s++) begin
      addr_i = {4'(s), 28'h0ab_cdef};
      lane_mode_i = 2'(s % 3);
      step();
      check(segment_o, s);
      check(lane_valid_o, s % 3 == 2 ? 4'hf : s % 3 == 1 ? 4'h3 : 4'h1);
    end
  endtask
  task automatic t_priv;
    {previous_context_info_we_i, ip_we_i} = 2'h3;
    {previous_context_info_wdata_i, ip_wdata_i} = {32'h0000_1230, 32'h0000_4560};
    step();
    {previous_context_info_we_i, ip_we_i} = 2'h0;
    check(previous_context_info_o, 32'h0000_1230);
    check(instruction_pointer_o, 32'h0000_4560);
    for (int m = 0; m < 4; m++) begin
      psw_we_i = 1'h1;
      psw_wdata_i = 32'(m) << 10;
      step();
      psw_we_i = 1'h0;
      {irq_disable_req_i, irq_toggle_req_i, periph_req_i, periph_protected_i} = 4'ha;
      sysreg_req_i = 1'h1;
      #1;
      check(program_status_word_o, 32'(m) << 10);
      check({priv_user0_o, priv_user1_o, priv_super_o}, m == 0 ? 3'h4 : m == 1 ? 3'h2 : 3'h1);
      check({irq_ctl_ok_o, periph_ok_o, sysreg_ok_o}, m == 0 ? 3'h0 : m == 1 ? 3'h6 : 3'h7);
      {irq_toggle_req_i, periph_protected_i} = 2'h3;
      #1;
      check({irq_ctl_ok_o, periph_ok_o}, m > 1 ? 2'h3 : 2'h0);
    end
  endtask
  task automatic t_align;
    csa_addr_i = 32'h0000_0104;
    brk_call_i = 1'h1;
    step();
    brk_call_i = 1'h0;
    step(2);
    check(csa_align_err_o, 1'h1);
    check({ctx_busy_o, csa_we_o}, 2'h0);
  endtask
  task automatic t_save_upper;
    slow = 1'h1;
    do_save(1'h1, 3'h1, 32'h0000_0100);
  endtask
  task automatic t_save_lower;
    slow = 1'h0;
    do_save(1'h0, 3'h2, 32'h0000_0100);
  endtask
  task automatic t_vector;
    vec_base_i = 32'h8000_0000;
    irq_src_i = 8'hff;
    do_save(1'h0, 3'h4, 32'h0000_0180);
    check(vector_addr_o, 32'h8000_1fe0);
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
  initial begin
    {d_we_i, d_implicit_i, a_we_i, a_implicit_i, psw_we_i, slow, previous_context_info_we_i, ip_we_i} = '0;
    {irq_toggle_req_i, irq_disable_req_i, periph_req_i, sysreg_req_i, periph_protected_i} = '0;
    {brk_irq_i, brk_trap_i, brk_call_i, ctx_upper_i, d_widx_i, d_ridx_i, a_widx_i} = '0;
    {a_ridx_i, lane_mode_i, irq_src_i, d_wdata_i, a_wdata_i, psw_wdata_i, addr_i} = '0;
    {previous_context_info_wdata_i, ip_wdata_i, vec_base_i, csa_addr_i, link_word_i} = '0;
    {ce_i, rst_i} = 2'h3;
    repeat (6) @(posedge clk_i);
    #1;
    rst_i = 1'h0;
    check(program_status_word_o, 32'h0000_0000);
    check({csa_we_o, ctx_busy_o}, 2'h0);
    t_regs();
    t_decode();
    t_priv();
    t_align();
    t_save_upper();
    t_save_lower();
    t_vector();
    finish_test();
  end
endmodule // tb
`default_nettype wire
